//--- verilog/xpc_pkg.sv
// package of constants and types for the crosspoint control-port host
package xpc_pkg;
    // ------------------------------------------------------------
    // device geometry
    // ------------------------------------------------------------
    localparam int          ROWS          = 17;       // outputs, one row each
    localparam int          WORD_W        = 7;        // connection word width
    localparam int          SEL_W         = 5;        // output-select width
    localparam int          INPUT_W       = 6;        // input-number field width
    localparam int          OE_BIT        = 6;        // output_enable_bit position
    localparam logic [4:0]  BROADCAST_SEL = 5'h11;    // select value 10001
    localparam logic [5:0]  MAX_INPUT     = 6'h20;    // highest input number, 32

    // ------------------------------------------------------------
    // timing, 40 MHz clock
    // ------------------------------------------------------------
    localparam int CLK_NS     = 25;                   // clock period
    localparam int STROBE_NS  = 15;                   // least strobe width
    localparam int SETUP_NS   = 15;                   // data to strobe setup
    localparam int WHU_NS     = 10;                   // write high to update
    localparam int ACCESS_NS  = 30;                   // readback access time
    localparam int RESET_NS   = 15;                   // least reset pulse
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_CYC  = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WHU_CYC    = (WHU_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS + 1;
    localparam int RESET_CYC  = (RESET_NS + CLK_NS - 1) / CLK_NS;

    // ------------------------------------------------------------
    // user-side commands
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        XPC_CMD_WRITE    = 2'h0,                      // load one first-rank row, or all rows on broadcast
        XPC_CMD_TRANSFER = 2'h1,                      // copy first rank to second
        XPC_CMD_READ     = 2'h2,                      // read back one second-rank row
        XPC_CMD_DISABLE  = 2'h3                       // pulse global output disable
    } xpc_cmd_t;

    // connection word layout
    typedef struct packed {
        logic        output_enable_bit;               // pair enabled when high
        logic [5:0]  input_num;                       // chosen input, msb first
    } xpc_word_t;

    // a user request
    typedef struct packed {
        xpc_cmd_t    cmd;                             // what to do
        logic [4:0]  sel;                             // output row or broadcast
        xpc_word_t   word;                            // write data
    } xpc_req_t;

    // port state machine, gray along write path
    typedef enum logic [2:0] {
        XPC_IDLE   = 3'b000,                          // nothing driven active
        XPC_SETUP  = 3'b001,                          // select and data settle
        XPC_STROBE = 3'b011,                          // strobe low
        XPC_RECOV  = 3'b010,                          // strobe high again
        XPC_DONE   = 3'b110                           // answer to user
    } xpc_state_t;
endpackage : xpc_pkg

//--- verilog/xpc_host.sv
// host controller that drives the crosspoint switch parallel control pins
module xpc_host (
    input  wire logic              clk,           // 40 MHz clock
    input  wire logic              rst,           // async reset, active high
    input  wire logic              req_valid,     // user request present
    input  wire xpc_pkg::xpc_req_t req,           // user request
    output logic                   req_ready,     // idle after the power-up disable
    output logic                   rsp_valid,     // one-cycle done pulse
    output xpc_pkg::xpc_word_t     rsp_word,      // readback word
    output logic                   init_done,     // all rows written once
    output logic                   xp_reset_n,    // global output disable
    output logic                   xp_cs_n,       // chip select
    output logic                   xp_we_n,       // first-rank write strobe
    output logic                   xp_update_n,   // transfer strobe
    output logic                   readback_enable_n, // readback enable
    output logic [4:0]             xp_sel,        // output select
    output logic [6:0]             xp_d_o,        // data to device
    output logic                   xp_d_oe,       // high while host drives data
    input  wire logic [6:0]        xp_d_i         // data from device
);
    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    xpc_pkg::xpc_state_t state_ff;                // port sequencer state
    xpc_pkg::xpc_state_t nxt_state;               // next state
    xpc_pkg::xpc_cmd_t   cmd_ff;                  // command being run
    logic [3:0]          cnt_ff;                  // phase cycle counter
    logic [3:0]          nxt_cnt;                 // next counter
    logic [16:0]         written_ff;              // rows written since reset
    logic                pwr_ff;                  // power-up disable done
    logic                init_done_ff;            // registered all-rows flag
    logic                req_ready_ff;            // registered ready
    logic                rsp_valid_ff;            // registered done
    xpc_pkg::xpc_word_t  rsp_word_ff;             // captured readback
    logic                rst_n_ff;                // reset pin
    logic                cs_n_ff;                 // chip select pin
    logic                we_n_ff;                 // write pin
    logic                upd_n_ff;                // transfer pin
    logic                re_n_ff;                 // readback pin
    logic [4:0]          sel_ff;                  // select pins
    logic [6:0]          d_ff;                    // data pins
    logic                d_oe_ff;                 // data drive enable

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic       idle       = (state_ff == xpc_pkg::XPC_IDLE);
    wire logic       pwr_pend   = !pwr_ff;                           // power-up disable pending
    // a transfer before every row has been written is held back
    wire logic       xfer_block = (req.cmd == xpc_pkg::XPC_CMD_TRANSFER) && !(&written_ff);
    // input numbers above 32 are reserved and refused at the user side
    wire logic       bad_input  = (req.cmd == xpc_pkg::XPC_CMD_WRITE) &&
                                  (req.word.input_num > xpc_pkg::MAX_INPUT);
    wire logic       bad_sel    = (req.cmd != xpc_pkg::XPC_CMD_TRANSFER) &&
                                  (req.cmd != xpc_pkg::XPC_CMD_DISABLE) &&
                                  (req.sel >= 5'(xpc_pkg::ROWS)) &&
                                  !((req.cmd == xpc_pkg::XPC_CMD_WRITE) &&
                                    (req.sel == xpc_pkg::BROADCAST_SEL));
    wire logic       take       = idle && !pwr_pend && req_valid && !xfer_block && !bad_input && !bad_sel;
    wire logic       is_read    = (cmd_ff == xpc_pkg::XPC_CMD_READ);
    wire logic       is_xfer    = (cmd_ff == xpc_pkg::XPC_CMD_TRANSFER);
    wire logic       is_dis     = (cmd_ff == xpc_pkg::XPC_CMD_DISABLE);
    // strobe phase length: readback waits out the access time
    wire logic [3:0] strobe_len = is_read ? 4'(xpc_pkg::ACCESS_CYC) :
                                  is_dis  ? 4'(xpc_pkg::RESET_CYC)  : 4'(xpc_pkg::STROBE_CYC);
    wire logic [3:0] setup_len  = 4'(xpc_pkg::SETUP_CYC);
    wire logic [3:0] recov_len  = 4'(xpc_pkg::WHU_CYC);
    wire logic       cnt_end    = (cnt_ff == 4'h1);
    wire logic [16:0] row_mask  = (sel_ff == xpc_pkg::BROADCAST_SEL) ? 17'h1ffff : (17'h1 << sel_ff);

    // ------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            xpc_pkg::XPC_IDLE: begin
                if (pwr_pend || take) begin
                    nxt_state = xpc_pkg::XPC_SETUP;
                    nxt_cnt   = setup_len;
                end
            end
            xpc_pkg::XPC_SETUP: begin
                if (cnt_end) begin
                    nxt_state = xpc_pkg::XPC_STROBE;
                    nxt_cnt   = strobe_len;
                end else begin
                    nxt_cnt = cnt_ff - 4'h1;
                end
            end
            xpc_pkg::XPC_STROBE: begin
                if (cnt_end) begin
                    nxt_state = xpc_pkg::XPC_RECOV;
                    nxt_cnt   = recov_len;
                end else begin
                    nxt_cnt = cnt_ff - 4'h1;
                end
            end
            xpc_pkg::XPC_RECOV: begin
                if (cnt_end) begin
                    nxt_state = xpc_pkg::XPC_DONE;
                end else begin
                    nxt_cnt = cnt_ff - 4'h1;
                end
            end
            xpc_pkg::XPC_DONE: begin
                nxt_state = xpc_pkg::XPC_IDLE;
            end
            default: begin
                nxt_state = xpc_pkg::XPC_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= xpc_pkg::XPC_IDLE;
            cnt_ff   <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // ------------------------------------------------------------
    // command capture; first job after reset is the disable pulse
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_ff <= xpc_pkg::XPC_CMD_DISABLE;
        end else if (idle && pwr_pend) begin
            cmd_ff <= xpc_pkg::XPC_CMD_DISABLE;
        end else if (take) begin
            cmd_ff <= req.cmd;
        end
    end

    // ------------------------------------------------------------
    // power-up and row bookkeeping
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwr_ff     <= 1'b0;
            written_ff <= 17'h0;
        end else if (state_ff == xpc_pkg::XPC_DONE) begin
            if (is_dis) begin
                pwr_ff <= 1'b1;
            end
            if (cmd_ff == xpc_pkg::XPC_CMD_WRITE) begin
                written_ff <= written_ff | row_mask;
            end
        end
    end

    // ------------------------------------------------------------
    // all-rows flag, registered so the output comes from a flop
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            init_done_ff <= 1'b0;
        end else begin
            init_done_ff <= &written_ff;
        end
    end

    // ------------------------------------------------------------
    // pin select and data, held through the whole cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_ff  <= 5'h0;
            d_ff    <= 7'h0;
            d_oe_ff <= 1'b0;
        end else if (take) begin
            sel_ff  <= req.sel;
            d_ff    <= req.word;
            d_oe_ff <= (req.cmd == xpc_pkg::XPC_CMD_WRITE);
        end else if (state_ff == xpc_pkg::XPC_DONE) begin
            d_oe_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // strobes: each held low only in strobe phase, chip select low through the whole access
    // ------------------------------------------------------------
    wire logic active  = (state_ff != xpc_pkg::XPC_IDLE) && (state_ff != xpc_pkg::XPC_DONE) && !is_dis;
    wire logic strobe  = (nxt_state == xpc_pkg::XPC_STROBE);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rst_n_ff <= 1'b1;
            cs_n_ff  <= 1'b1;
            we_n_ff  <= 1'b1;
            upd_n_ff <= 1'b1;
            re_n_ff  <= 1'b1;
        end else begin
            rst_n_ff <= !(strobe && is_dis);
            cs_n_ff  <= !(active || (take && req.cmd != xpc_pkg::XPC_CMD_DISABLE));
            we_n_ff  <= !(strobe && cmd_ff == xpc_pkg::XPC_CMD_WRITE);
            upd_n_ff <= !(strobe && is_xfer);
            re_n_ff  <= !(strobe && is_read);
        end
    end

    // ------------------------------------------------------------
    // handshake and readback capture at end of access time
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_ready_ff <= 1'b0;
            rsp_valid_ff <= 1'b0;
            rsp_word_ff  <= '0;
        end else begin
            req_ready_ff <= (nxt_state == xpc_pkg::XPC_IDLE) && pwr_ff;
            rsp_valid_ff <= (state_ff == xpc_pkg::XPC_DONE) && !is_dis;
            if (state_ff == xpc_pkg::XPC_STROBE && cnt_end && is_read) begin
                rsp_word_ff <= xp_d_i;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign req_ready         = req_ready_ff;
    assign rsp_valid         = rsp_valid_ff;
    assign rsp_word          = rsp_word_ff;
    assign init_done         = init_done_ff;
    assign xp_reset_n        = rst_n_ff;
    assign xp_cs_n           = cs_n_ff;
    assign xp_we_n           = we_n_ff;
    assign xp_update_n       = upd_n_ff;
    assign readback_enable_n = re_n_ff;
    assign xp_sel            = sel_ff;
    assign xp_d_o            = d_ff;
    assign xp_d_oe           = d_oe_ff;
endmodule : xpc_host

//--- sim/xpc_host_chk.sv
// checker of the pin sequencing driven by the crosspoint port host
module xpc_host_chk (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       rsp_valid,
    input wire logic       init_done,
    input wire logic       xp_reset_n,
    input wire logic       xp_cs_n,
    input wire logic       xp_we_n,
    input wire logic       xp_update_n,
    input wire logic       readback_enable_n,
    input wire logic [4:0] xp_sel,
    input wire logic [6:0] xp_d_o,
    input wire logic       xp_d_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // named steps of the write and readback walks
    // ------------------------------------------------------------
    sequence s_write_tail;
        ##1 xp_we_n ##2 rsp_valid;
    endsequence
    sequence s_read_walk;
        !readback_enable_n [*3] ##1 readback_enable_n ##2 rsp_valid;
    endsequence
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_write_cs: assert property (!xp_we_n |-> !xp_cs_n)
        else $error("write strobe low without chip select");
    a_write_tail: assert property ($fell(xp_we_n) |-> s_write_tail)
        else $error("write strobe not released or no done pulse");
    a_write_setup: assert property ($fell(xp_we_n) |-> xp_d_oe && $stable(xp_sel) && $stable(xp_d_o))
        else $error("select or data not settled before write strobe");
    a_update_cs: assert property (!xp_update_n |-> !xp_cs_n)
        else $error("transfer strobe low without chip select");
    a_update_init: assert property ($fell(xp_update_n) |-> init_done)
        else $error("transfer before every row was written");
    a_update_after_we: assert property (!xp_update_n |-> xp_we_n && $past(xp_we_n))
        else $error("transfer overlaps a write strobe");
    a_read_walk: assert property ($fell(readback_enable_n) |-> s_read_walk)
        else $error("readback strobe length or answer wrong");
    a_no_contention: assert property (!readback_enable_n |-> !xp_d_oe)
        else $error("host drives data during readback");
    a_read_sel: assert property (!readback_enable_n |-> xp_sel < 5'h11)
        else $error("readback of a row that does not exist");
    a_powerup_disable: assert property ($fell(rst) |-> ##[0:6] (!xp_reset_n && xp_cs_n))
        else $error("no output disable pulse after power-up");
endmodule : xpc_host_chk

bind xpc_host xpc_host_chk i_xpc_host_chk (.clk(clk), .rst(rst), .rsp_valid(rsp_valid), .init_done(init_done),
    .xp_reset_n(xp_reset_n), .xp_cs_n(xp_cs_n), .xp_we_n(xp_we_n), .xp_update_n(xp_update_n),
    .readback_enable_n(readback_enable_n), .xp_sel(xp_sel), .xp_d_o(xp_d_o), .xp_d_oe(xp_d_oe));

//--- sim/xpc_dev_model.sv
// behavioural model of the crosspoint control port, level-sensitive latches
module xpc_dev_model (
    input  wire logic       reset_n,
    input  wire logic       cs_n,
    input  wire logic       we_n,
    input  wire logic       update_n,
    input  wire logic       readback_enable_n,
    input  wire logic [4:0] sel,
    input  wire logic [6:0] bus_d,
    output logic      [6:0] read_d,
    output logic            read_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] pending_connection_row [17];  // first rank, undefined at power-up
    logic [6:0] active_connection_row  [17];  // second rank, drives the matrix
    // every control acts on its level, re-evaluated on any pin change
    always @(reset_n or cs_n or we_n or update_n or readback_enable_n or sel or bus_d) begin
        if (!cs_n && !we_n) begin
            for (int i = 0; i < 17; i++) begin
                if (sel == xpc_pkg::BROADCAST_SEL || sel == 5'(i)) begin
                    pending_connection_row[i] = bus_d;
                end
            end
        end
        if (!cs_n && !update_n) begin
            for (int i = 0; i < 17; i++) begin
                active_connection_row[i] = pending_connection_row[i];
            end
        end
        if (!reset_n) begin
            for (int i = 0; i < 17; i++) begin
                active_connection_row[i][6] = 1'b0;
            end
        end
        // drivers float unless selected and reading; write may overlap
        read_oe = !cs_n && !readback_enable_n;
        if (sel < 5'h11) begin
            read_d = active_connection_row[sel];
        end else begin
            read_d = ~read_d;
        end
    end
endmodule : xpc_dev_model

//--- sim/xpc_host_test.sv
// self-checking testbench of the crosspoint port host against the device model
module xpc_host_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic                clk;
    logic                rst;
    logic                req_valid;
    xpc_pkg::xpc_req_t   req;
    logic                req_ready, rsp_valid, init_done;
    xpc_pkg::xpc_word_t  rsp_word;
    logic                xp_reset_n, xp_cs_n, xp_we_n, xp_update_n, readback_enable_n, xp_d_oe;
    logic [4:0]          xp_sel;
    logic [6:0]          xp_d_o, read_d;
    logic                read_oe;
    wire logic [6:0]     bus_d = read_oe ? read_d : (xp_d_oe ? xp_d_o : ~xp_d_o); // resolved data wire
    int                  err_total = 0;
    int                  n_tests = 0;
    xpc_host i_xpc_host (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_word(rsp_word), .init_done(init_done), .xp_reset_n(xp_reset_n),
        .xp_cs_n(xp_cs_n), .xp_we_n(xp_we_n), .xp_update_n(xp_update_n), .readback_enable_n(readback_enable_n),
        .xp_sel(xp_sel), .xp_d_o(xp_d_o), .xp_d_oe(xp_d_oe), .xp_d_i(bus_d));
    xpc_dev_model i_xpc_dev_model (.reset_n(xp_reset_n), .cs_n(xp_cs_n), .we_n(xp_we_n), .update_n(xp_update_n),
        .readback_enable_n(readback_enable_n), .sel(xp_sel), .bus_d(bus_d), .read_d(read_d), .read_oe(read_oe));
    // ------------------------------------------------------------
    // clock, verdict and watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_sim;
    end
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [6:0] got, input logic [6:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one request held until answered, until the reset pin falls for a disable, or for 16 cycles when refused
    task automatic go(input xpc_pkg::xpc_cmd_t c, input logic [4:0] s, input logic [6:0] w, input logic ok,
                      output logic [6:0] rd);
        logic got;
        logic quit;
        got = 1'b0;
        quit = 1'b0;
        @(negedge clk);
        req_valid = 1'b1;
        req = {c, s, w};
        for (int n = 0; n < 16 && !quit; n++) begin
            @(posedge clk);
            #1;
            got = got | (rsp_valid === 1'b1);
            quit = got | (c == xpc_pkg::XPC_CMD_DISABLE && xp_reset_n === 1'b0);
        end
        rd = rsp_word;
        @(negedge clk);
        req_valid = 1'b0;
        chk({6'h00, got}, {6'h00, ok});
    endtask : go
    task automatic rd_chk(input logic [4:0] s, input logic [6:0] exp);
        logic [6:0] v;
        go(xpc_pkg::XPC_CMD_READ, s, 7'h00, 1'b1, v);
        chk(v, exp);
    endtask : rd_chk
    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        logic [6:0] d;
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        for (int n = 0; n < 20 && req_ready !== 1'b1; n++) @(negedge clk);
        chk({6'h00, req_ready}, 7'h01);
        go(xpc_pkg::XPC_CMD_TRANSFER, 5'h00, 7'h00, 1'b0, d);
        go(xpc_pkg::XPC_CMD_WRITE, 5'h11, 7'h47, 1'b1, d);
        go(xpc_pkg::XPC_CMD_WRITE, 5'h10, 7'h60, 1'b1, d);
        go(xpc_pkg::XPC_CMD_WRITE, 5'h03, 7'h21, 1'b0, d);
        chk({6'h00, init_done}, 7'h01);
        go(xpc_pkg::XPC_CMD_TRANSFER, 5'h00, 7'h00, 1'b1, d);
        for (int r = 0; r < 17; r++) rd_chk(5'(r), (r == 16) ? 7'h60 : 7'h47);
        go(xpc_pkg::XPC_CMD_READ, 5'h11, 7'h00, 1'b0, d);
        go(xpc_pkg::XPC_CMD_WRITE, 5'h05, 7'h5f, 1'b1, d);
        rd_chk(5'h05, 7'h47);
        go(xpc_pkg::XPC_CMD_TRANSFER, 5'h00, 7'h00, 1'b1, d);
        rd_chk(5'h05, 7'h5f);
        go(xpc_pkg::XPC_CMD_DISABLE, 5'h00, 7'h00, 1'b0, d);
        rd_chk(5'h05, 7'h1f);
        rd_chk(5'h10, 7'h20);
        go(xpc_pkg::XPC_CMD_TRANSFER, 5'h00, 7'h00, 1'b1, d);
        rd_chk(5'h05, 7'h5f);
        rd_chk(5'h00, 7'h47);
        end_sim;
    end
endmodule : xpc_host_test
